// File: src/e1tx_framer.sv
/*
  E1 transmit framer with receive synchronizer status outputs.
  Assumes tx_primary_clock is the 2.048 MHz link clock, unrelated to mclk_in;
  transmit pins are synchronous to tx_primary_clock; the search inputs
  and CRC4 events come from receive logic on mclk_in.
*/
`include "e1tx_map.svh"
`default_nettype none
module e1tx_framer (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic tx_primary_clock,
   input wire logic tx_multiframe_sync_in,
   input wire logic tx_frame_sync_in,
   input wire logic tx_channel_data_in,
   input wire logic tx_extra_data_in,
   input wire logic tx_signaling_data_in,
   input wire logic tx_intl_national_bits_in,
   input wire logic cas_enable_in,
   input wire logic signaling_insert_enable_in,
   input wire logic intl_insert_enable_in,
   input wire logic natl_insert_enable_in,
   input wire logic rx_multiframe_search_in,
   input wire logic rx_frame_search_in,
   input wire logic rx_crc_search_in,
   input wire logic crc_timeout_tick_in,
   input wire logic crc_sync_achieved_in,
   input wire logic crc4_enable_in,
   input wire logic common_ctrl_status_enable_in,
   input wire logic processor_mode_in,
   input wire logic test_mode_in,
   output logic tx_timeslot_clock_out,
   output logic tx_multiframe_counter_out,
   output logic tx_signaling_slot_flag_out,
   output logic tx_alignment_frame_flag_out,
   output logic tx_line_positive_out,
   output logic tx_line_negative_out,
   output logic rx_multiframe_search_flag_out,
   output logic rx_frame_search_flag_out,
   output logic rx_crc_timeout_flag_out,
   output logic rx_crc_search_flag_out,
   output logic rx_status_oe_out
);
   e1tx_pkg::e1tx_mclk_st_t m;
   e1tx_pkg::e1tx_mclk_st_t next_m;
   e1tx_pkg::e1tx_link_st_t l;
   e1tx_pkg::e1tx_link_st_t next_l;
   e1tx_pkg::e1tx_samp_st_t s;
   e1tx_pkg::e1tx_samp_st_t next_s;
   logic lrst;
   logic [4:0] slot;
   logic [3:0] bitn;
   logic mf_edge;
   logic fr_edge;
   logic status_en;
   logic [6:0] fas_word;

   // Alignment word kept as a vector so a single bit can be picked by position
   assign fas_word = `E1TX_FAS_WORD;

   // Main clock domain: synchronizer status and CRC4 timeout
   always_comb begin
      next_m = m;
      next_m.test_s1 = test_mode_in;
      next_m.test_s2 = m.test_s1;
      next_m.proc_s1 = processor_mode_in;
      next_m.proc_s2 = m.proc_s1;
      next_m.status.mf_search = rx_multiframe_search_in; // RULE_14
      next_m.status.frame_search = rx_frame_search_in; // RULE_15
      next_m.status.crc_search = rx_crc_search_in; // RULE_18
      if (crc_sync_achieved_in || !crc4_enable_in) begin
         next_m.crc_cnt = `E1TX_CRC_CNT_RST; // RULE_17
         next_m.status.crc_timeout = 1'b0; // RULE_17
      end else if (crc_timeout_tick_in && m.crc_cnt != `E1TX_CRC_TO_MAX) begin
         next_m.crc_cnt = m.crc_cnt + 6'h01;
         if (m.crc_cnt == `E1TX_CRC_TO_MAX - 6'h01) begin
            next_m.status.crc_timeout = 1'b1; // RULE_16
         end
      end
      // Status enable bit is a host feature, ignored in hardware mode
      next_m.status_oe = m.test_s2 || (m.proc_s2 && common_ctrl_status_enable_in); // RULE_21 RULE_19 RULE_20
      if (!rst_n_in) begin
         next_m.crc_cnt = `E1TX_CRC_CNT_RST;
         next_m.status = '0; // RULE_17
         next_m.status_oe = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      m <= next_m;
   end

   assign status_en = m.test_s2 || (m.proc_s2 && common_ctrl_status_enable_in);
   assign rx_multiframe_search_flag_out = m.status.mf_search;
   assign rx_frame_search_flag_out = m.status.frame_search;
   assign rx_crc_search_flag_out = m.status.crc_search;
   assign rx_crc_timeout_flag_out = m.status.crc_timeout;
   assign rx_status_oe_out = m.status_oe;

   // Link domain, rising edges: counters, markers and line drive
   assign lrst = !l.rst_s2;
   assign slot = l.pos[7:3];
   assign bitn = {1'b0, l.pos[2:0]} + 4'h1;
   assign mf_edge = s.ms_rise;
   assign fr_edge = s.fs_rise;

   always_comb begin
      next_l = l;
      next_l.rst_s1 = rst_n_in;
      next_l.rst_s2 = l.rst_s1;
      next_l.ctrl_s1 = {natl_insert_enable_in, intl_insert_enable_in,
                        signaling_insert_enable_in, cas_enable_in};
      next_l.ctrl_s2 = l.ctrl_s1;
      if (mf_edge) begin
         next_l.pos = `E1TX_POS_RST; // RULE_01
         next_l.frame = `E1TX_FRAME_RST; // RULE_01
      end else if (fr_edge) begin
         next_l.pos = `E1TX_POS_RST; // RULE_02
         // A frame sync cutting a frame short still starts the next frame
         if (l.pos != `E1TX_POS_RST) begin
            next_l.frame = l.frame + 4'h1;
         end
      end else begin
         next_l.pos = l.pos + 8'h01; // RULE_23
         if (l.pos == 8'hFF) begin
            next_l.frame = l.frame + 4'h1; // RULE_01
         end
      end
      next_l.slot_clk = (next_l.pos[2:0] < `E1TX_SLOT_CLK_HALF); // RULE_04
      next_l.mf_out = (next_l.frame == `E1TX_FRAME_RST); // RULE_06
      next_l.sig_slot = (next_l.pos[7:3] == `E1TX_SLOT_SIG); // RULE_08
      next_l.align_frame = !next_l.frame[0]; // RULE_12
      // Alternate mark inversion of the bit captured on the falling edge
      next_l.line_pos = s.line_bit && !l.mark_neg; // RULE_13
      next_l.line_neg = s.line_bit && l.mark_neg; // RULE_13
      if (s.line_bit) begin
         next_l.mark_neg = !l.mark_neg;
      end
      if (lrst) begin
         next_l.pos = `E1TX_POS_RST;
         next_l.frame = `E1TX_FRAME_RST;
         next_l.mark_neg = 1'b0;
         next_l.slot_clk = 1'b1;
         next_l.mf_out = 1'b1;
         next_l.sig_slot = 1'b0;
         next_l.align_frame = 1'b1;
         next_l.line_pos = 1'b0;
         next_l.line_neg = 1'b0;
      end
   end

   always_ff @(posedge tx_primary_clock) begin
      l <= next_l;
   end

   // Link domain, falling edges: every transmit input is sampled here
   always_comb begin
      next_s = s;
      next_s.fs_prev = tx_frame_sync_in;
      next_s.ms_prev = tx_multiframe_sync_in;
      next_s.fs_rise = tx_frame_sync_in && !s.fs_prev; // RULE_02
      next_s.ms_rise = tx_multiframe_sync_in && !s.ms_prev; // RULE_01
      next_s.line_bit = tx_channel_data_in; // RULE_05
      if (slot == `E1TX_SLOT_FAS) begin
         if (bitn == 4'h1) begin
            next_s.line_bit = l.ctrl_s2[`E1TX_CTRL_INTL] ? tx_intl_national_bits_in : 1'b1; // RULE_10
         end else if (!l.frame[0]) begin
            next_s.line_bit = fas_word[3'(4'h8 - bitn)];
         end else if (bitn == 4'h2) begin
            next_s.line_bit = 1'b1;
         end else if (bitn == 4'h3) begin
            next_s.line_bit = 1'b0;
         end else begin
            next_s.line_bit = l.ctrl_s2[`E1TX_CTRL_NATL] ? tx_intl_national_bits_in : 1'b1; // RULE_11
         end
      end else if (slot == `E1TX_SLOT_SIG && l.frame == `E1TX_FRAME_RST && l.ctrl_s2[`E1TX_CTRL_CAS]) begin
         if (bitn == 4'h5 || bitn == 4'h7 || bitn == 4'h8) begin
            next_s.line_bit = tx_extra_data_in; // RULE_07
         end else begin
            next_s.line_bit = 1'b0;
         end
      end else if (slot == `E1TX_SLOT_SIG && l.ctrl_s2[`E1TX_CTRL_SIG]) begin
         next_s.line_bit = tx_signaling_data_in; // RULE_09
      end
      if (lrst) begin
         next_s.fs_rise = 1'b0;
         next_s.ms_rise = 1'b0;
         next_s.line_bit = 1'b0;
      end
   end

   always_ff @(negedge tx_primary_clock) begin
      s <= next_s;
   end

   assign tx_timeslot_clock_out = l.slot_clk;
   assign tx_multiframe_counter_out = l.mf_out;
   assign tx_signaling_slot_flag_out = l.sig_slot;
   assign tx_alignment_frame_flag_out = l.align_frame;
   assign tx_line_positive_out = l.line_pos;
   assign tx_line_negative_out = l.line_neg;

   // Checks in the link domain
   sequence slot_high_run;
      tx_signaling_slot_flag_out [*8];
   endsequence
   sequence slot_low_after;
      !tx_signaling_slot_flag_out [*8];
   endsequence

   a_sig_slot_len: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_08
      $rose(tx_signaling_slot_flag_out) && !mf_edge && !fr_edge |-> slot_high_run ##1 slot_low_after
      or ##[1:8] (mf_edge || fr_edge))
      else $error("signaling slot flag not eight bits wide");

   // A sync edge only ever restarts the slot at bit 1, so the high half is never cut short
   sequence clk_high4;
      tx_timeslot_clock_out [*4];
   endsequence

   a_slot_clk_period: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_04
      $rose(tx_timeslot_clock_out) |-> clk_high4)
      else $error("timeslot clock high half malformed");

   a_slot_clk_shape: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_04
      (l.pos[2:0] == 3'h7) && !mf_edge && !fr_edge |=> tx_timeslot_clock_out ##4 !tx_timeslot_clock_out)
      else $error("timeslot clock edges off slot boundary");

   a_mf_frame0: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_06
      ##1 (tx_multiframe_counter_out == (l.frame == `E1TX_FRAME_RST)))
      else $error("multiframe output not tied to frame 0");

   a_ms_resync: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_01
      mf_edge |=> l.pos == `E1TX_POS_RST && l.frame == `E1TX_FRAME_RST && tx_multiframe_counter_out)
      else $error("multiframe sync did not restart multiframe");

   a_fs_resync: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_02
      fr_edge && !mf_edge |=> l.pos == `E1TX_POS_RST)
      else $error("frame sync did not restart frame");

   a_align_alt: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_12
      ##1 (tx_alignment_frame_flag_out == !l.frame[0]))
      else $error("alignment frame flag wrong");

   a_line_ami: assert property (@(posedge tx_primary_clock) disable iff (lrst) // RULE_13
      !(tx_line_positive_out && tx_line_negative_out)
      and ($past(s.line_bit) |-> (tx_line_positive_out || tx_line_negative_out)))
      else $error("bipolar line output wrong");

   a_tx_intl_national_bits_in_intl: assert property (@(negedge tx_primary_clock) disable iff (lrst) // RULE_10
      slot == `E1TX_SLOT_FAS && bitn == 4'h1 && l.ctrl_s2[`E1TX_CTRL_INTL]
      |=> s.line_bit == $past(tx_intl_national_bits_in))
      else $error("international bit not taken from input");

   // Checks in the main clock domain
   a_crc_to_rise: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE_16
      m.crc_cnt == `E1TX_CRC_TO_MAX - 6'h01 && crc_timeout_tick_in && crc4_enable_in
      && !crc_sync_achieved_in |=> rx_crc_timeout_flag_out && m.crc_cnt == `E1TX_CRC_TO_MAX)
      else $error("CRC4 timeout flag missed count of 32");

   a_crc_to_clear: assert property (@(posedge mclk_in) // RULE_17
      (crc_sync_achieved_in || !crc4_enable_in || !rst_n_in) |=> !rx_crc_timeout_flag_out)
      else $error("CRC4 timeout flag not cleared");

   a_crc_to_early: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE_16
      m.crc_cnt < `E1TX_CRC_TO_MAX |-> !rx_crc_timeout_flag_out)
      else $error("CRC4 timeout flag raised before count of 32");

   a_search_follow: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE_15 RULE_14 RULE_18
      rx_frame_search_in && rx_multiframe_search_in && rx_crc_search_in
      |=> rx_frame_search_flag_out && rx_multiframe_search_flag_out && rx_crc_search_flag_out)
      else $error("search flag not raised");

   a_status_float: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE_21
      !status_en |=> !rx_status_oe_out)
      else $error("status outputs driven while disabled");

   a_hw_mode: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE_20
      !m.proc_s2 && !m.test_s2 |=> !rx_status_oe_out)
      else $error("host status enable honoured in hardware mode");
endmodule
`default_nettype wire

// File: src/e1tx_map.svh
/*
  Constants of the E1 transmit framer and synchronizer status block.
  Assumes inclusion by bare name from the package and the framer.
*/
// Notes on behaviour
// RULE_01: Multiframe sync rising edge starts the multiframe; held low, multiframe counter free-runs.
// RULE_02: Frame sync rising edge sets frame boundaries; held low, multiframe sync does it.
// RULE_03: Outside party supplies a 2.048 MHz transmit clock referencing all transmit timing.
// RULE_04: A 256 kHz timeslot clock is output, edges on timeslot boundaries.
// RULE_05: Channel data is sampled on falling transmit clock edges; party keeps it valid.
// RULE_06: Multiframe counter output is high during frame 0 only.
// RULE_07: With CAS enabled, extra data sampled in bits 5, 7, 8 of slot 16, frame 0.
// RULE_08: Signaling slot flag is high for all of timeslot 16, every frame.
// RULE_09: With insertion enabled, signaling data is sampled on falling edges into slot 16.
// RULE_10: With international insertion on, bit 1 of slot 0 is sampled every frame.
// RULE_11: With national insertion on, bits 4 to 8 of slot 0 sampled in non-align frames.
// RULE_12: Alignment frame flag is high in frames carrying the alignment signal.
// RULE_13: Bipolar line outputs change on rising transmit clock edges.
// RULE_14: Multiframe search flag is high while the CAS multiframe hunt is active.
// RULE_15: Frame search flag is high while the frame alignment hunt is active.
// RULE_16: CRC4 timeout flag rises when the timeout counter reaches 32.
// RULE_17: CRC4 timeout flag falls on CRC4 sync, CRC4 disable or hardware reset.
// RULE_18: CRC4 search flag is high while the CRC4 multiframe hunt is active.
// RULE_19: In processor mode the host control bits are honoured.
// RULE_20: In hardware mode processor-only features are disabled.
// RULE_21: Status outputs float while test input is low and status enable is zero.
// RULE_22: Outside party asserts reset at power-up and on mode changes.
// RULE_23: Frames are 32 slots of 8 bits, counters aligned to frame sync.
`ifndef E1TX_MAP_SVH
`define E1TX_MAP_SVH
`define E1TX_LINE_CLK_KHZ 2048
`define E1TX_SLOT_CLK_KHZ 256
`define E1TX_BITS_PER_SLOT (`E1TX_LINE_CLK_KHZ / `E1TX_SLOT_CLK_KHZ)
`define E1TX_SLOT_CLK_HALF 3'h4
`define E1TX_POS_W 8
`define E1TX_FRAME_W 4
`define E1TX_POS_RST 8'h00
`define E1TX_FRAME_RST 4'h0
`define E1TX_SLOT_SIG 5'h10
`define E1TX_SLOT_FAS 5'h00
`define E1TX_FAS_WORD 7'h1B
`define E1TX_CRC_TO_MAX 6'h20
`define E1TX_CRC_CNT_RST 6'h00
`define E1TX_CTRL_CAS 0
`define E1TX_CTRL_SIG 1
`define E1TX_CTRL_INTL 2
`define E1TX_CTRL_NATL 3
`define E1TX_CTRL_W 4
`endif

// File: src/e1tx_pkg.sv
/*
  Types of the E1 transmit framer: state records of each clock domain.
  Assumes e1tx_map.svh for widths.
*/
`include "e1tx_map.svh"
`default_nettype none
package e1tx_pkg;
   typedef struct packed {
      logic mf_search;
      logic frame_search;
      logic crc_search;
      logic crc_timeout;
   } e1tx_status_t;
   typedef struct packed {
      logic test_s1;
      logic test_s2;
      logic proc_s1;
      logic proc_s2;
      logic [5:0] crc_cnt;
      e1tx_status_t status;
      logic status_oe;
   } e1tx_mclk_st_t;
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [`E1TX_CTRL_W-1:0] ctrl_s1;
      logic [`E1TX_CTRL_W-1:0] ctrl_s2;
      logic [`E1TX_POS_W-1:0] pos;
      logic [`E1TX_FRAME_W-1:0] frame;
      logic mark_neg;
      logic slot_clk;
      logic mf_out;
      logic sig_slot;
      logic align_frame;
      logic line_pos;
      logic line_neg;
   } e1tx_link_st_t;
   typedef struct packed {
      logic fs_prev;
      logic ms_prev;
      logic fs_rise;
      logic ms_rise;
      logic line_bit;
   } e1tx_samp_st_t;
endpackage
`default_nettype wire

// File: tb/e1tx_partner.sv
/*
  System-side framing logic in front of the transmit framer: makes the link
  clock, the sync pulses and random serial data for every data input.
  Assumes go_in rises once, after the link logic has left reset.
*/
`default_nettype none
module e1tx_partner (
   input wire logic go_in,
   output logic lclk_out,
   output logic msync_out,
   output logic fsync_out,
   output logic chan_out,
   output logic extra_out,
   output logic sig_out,
   output logic ind_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 42528;
   int cnt = -1;
   initial begin
      lclk_out = 1'b0;
      forever #80 lclk_out = ~lclk_out;
   end
   initial begin
      msync_out = 1'b0;
      fsync_out = 1'b0;
   end
   // Data moves just after the rising edge, so it is steady at the falling sample
   always @(posedge lclk_out) begin
      chan_out <= 1'($random(seed));
      extra_out <= 1'($random(seed));
      sig_out <= 1'($random(seed));
      ind_out <= 1'($random(seed));
      if (go_in && cnt < 0) cnt <= 0;
      else if (cnt >= 0) cnt <= cnt + 1;
      msync_out <= go_in && cnt < 0;
      fsync_out <= (go_in && cnt < 0) || (cnt >= 0 && (cnt + 1) % 256 == 0);
   end
endmodule
`default_nettype wire

// File: tb/e1_transmit_framer_sync_status_test.sv
/*
  Self-checking bench of the transmit framer and its status outputs.
  Assumes e1tx_framer and the partner model; 125 MHz main clock.
*/
`default_nettype none
module e1_transmit_framer_sync_status_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic go = 1'b0;
   logic rx_ms = 1'b0, rx_fs = 1'b0, rx_cs = 1'b0, tick = 1'b0, sync_ach = 1'b0, crc4_en = 1'b1;
   logic status_en = 1'b0, proc = 1'b0, test = 1'b0;
   logic lclk, msync, fsync, chan, extra, sig, ind;
   logic slot_clk, mf_out, sig_slot, align, lp, ln, ms_flag, fs_flag, to_flag, cs_flag, oe;
   int seed = 42528;
   int n_fail = 0;
   int comparisons = 0;
   int i, mode, m = -1000, p, f;
   logic ms_d = 1'b0, exp_prev = 1'b0, last_neg = 1'b0, seen_mark = 1'b0;
   initial begin
      forever #4 mclk_in = ~mclk_in;
   end
   e1tx_partner e1tx_partner_inst (.go_in(go), .lclk_out(lclk), .msync_out(msync), .fsync_out(fsync),
      .chan_out(chan), .extra_out(extra), .sig_out(sig), .ind_out(ind));
   // Enables stay on: bits with insertion off have no documented value to compare
   e1tx_framer e1tx_framer_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tx_primary_clock(lclk),
      .tx_multiframe_sync_in(msync), .tx_frame_sync_in(fsync), .tx_channel_data_in(chan),
      .tx_extra_data_in(extra), .tx_signaling_data_in(sig), .tx_intl_national_bits_in(ind),
      .cas_enable_in(1'b1), .signaling_insert_enable_in(1'b1), .intl_insert_enable_in(1'b1),
      .natl_insert_enable_in(1'b1), .rx_multiframe_search_in(rx_ms), .rx_frame_search_in(rx_fs),
      .rx_crc_search_in(rx_cs), .crc_timeout_tick_in(tick), .crc_sync_achieved_in(sync_ach),
      .crc4_enable_in(crc4_en), .common_ctrl_status_enable_in(status_en), .processor_mode_in(proc),
      .test_mode_in(test), .tx_timeslot_clock_out(slot_clk), .tx_multiframe_counter_out(mf_out),
      .tx_signaling_slot_flag_out(sig_slot), .tx_alignment_frame_flag_out(align),
      .tx_line_positive_out(lp), .tx_line_negative_out(ln), .rx_multiframe_search_flag_out(ms_flag),
      .rx_frame_search_flag_out(fs_flag), .rx_crc_timeout_flag_out(to_flag),
      .rx_crc_search_flag_out(cs_flag), .rx_status_oe_out(oe));
   task automatic check(input logic seen, input logic exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic line_bit(input int p, input int f, input logic ch, input logic ex,
         input logic sg, input logic nb);
      int s;
      int b;
      logic [6:0] align_word;
      s = p / 8;
      b = p % 8 + 1;
      align_word = 7'h1b;
      if (s == 0 && b == 1) return nb;
      if (s == 0 && f % 2 == 0) return align_word[8 - b];
      if (s == 0 && b < 4) return logic'(b == 2);
      if (s == 0) return nb;
      if (s == 16 && f % 16 == 0) return (b == 5 || b == 7 || b == 8) ? ex : 1'b0;
      if (s == 16) return sg;
      return ch;
   endfunction
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         tick <= 1'b1;
         @(posedge mclk_in);
         tick <= 1'b0;
      end
      #1;
   endtask
   // Position count restarts from the multiframe sync edge the design sees
   always @(negedge lclk) begin
      if (msync && !ms_d) m = -1;
      else if (m > -2) m = m + 1;
      ms_d = msync;
      if (m >= 0 && m < 768) begin
         p = m % 256;
         f = m / 256;
         check(slot_clk, logic'(p % 8 < 4), "slot clock");
         check(sig_slot, logic'(p / 8 == 16), "signaling slot flag");
         check(mf_out, logic'(f % 16 == 0), "multiframe out");
         check(align, logic'(f % 2 == 0), "alignment frame flag");
         if (m > 0) begin
            check(lp ^ ln, exp_prev, "line bit");
            if (lp | ln) begin
               if (seen_mark) check(lp, last_neg, "mark polarity");
               last_neg = ln;
               seen_mark = 1'b1;
            end
         end
         exp_prev = line_bit(p, f, chan, extra, sig, ind);
      end
   end
   initial begin
      // Link reset passes two flops, so hold well past three link edges
      repeat (64) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge mclk_in);
         {rx_ms, rx_fs, rx_cs} <= 3'($random(seed));
         @(posedge mclk_in);
         #1;
         check(ms_flag, rx_ms, "multiframe search");
         check(fs_flag, rx_fs, "frame search");
         check(cs_flag, rx_cs, "crc search");
      end
      $display("Search flag test done");
      for (mode = 0; mode < 3; mode++) begin
         ticks(31);
         check(to_flag, 1'b0, "timeout early");
         ticks(1);
         check(to_flag, 1'b1, "timeout at 32");
         @(posedge mclk_in);
         if (mode == 0) sync_ach <= 1'b1;
         else if (mode == 1) crc4_en <= 1'b0;
         else rst_n_in <= 1'b0;
         @(posedge mclk_in);
         sync_ach <= 1'b0;
         crc4_en <= 1'b1;
         #1;
         check(to_flag, 1'b0, "timeout clear");
         repeat (64) @(posedge mclk_in);
         rst_n_in <= 1'b1;
      end
      $display("Timeout test done");
      for (i = 0; i < 8; i++) begin
         @(posedge mclk_in);
         {status_en, proc, test} <= 3'(i);
         repeat (4) @(posedge mclk_in);
         #1;
         check(oe, test | (proc & status_en), "status output enable");
      end
      $display("Output enable test done");
      @(posedge mclk_in);
      go <= 1'b1;
      for (i = 0; i < 20000 && m < 768; i++) @(posedge mclk_in);
      if (m < 768) begin
         n_fail++;
         $display("wrong value at %0t: link frames not seen", $time);
      end
      $display("Link framing test done");
      give_verdict();
   end
endmodule
`default_nettype wire
